// *** core/scp_pkg.sv ***
// Constants and carrier types shared by the serial port one controller.
package scp_pkg;

	localparam logic [7:0] ADDR_CONTROL = 8'hc0;
	localparam logic [7:0] ADDR_BUFFER = 8'hc1;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] BUFFER_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	localparam int BIT_MODE_HIGH = 7;
	localparam int BIT_MODE_LOW = 6;
	localparam int BIT_MULTIPROC = 5;
	localparam int BIT_RX_ENABLE = 4;
	localparam int BIT_TX_NINTH = 3;
	localparam int BIT_RX_NINTH = 2;
	localparam int BIT_TX_COMPLETE = 1;
	localparam int BIT_RX_COMPLETE = 0;

	localparam logic [1:0] MODE_SYNC = 2'h0;
	localparam logic [1:0] MODE_ASYNC10 = 2'h1;
	localparam logic [1:0] MODE_ASYNC11_FIXED = 2'h2;
	localparam logic [1:0] MODE_ASYNC11_TIMER = 2'h3;

	localparam int CLOCK_MHZ = 40;
	localparam logic [3:0] SYNC_PERIOD_SLOW = 4'hc;
	localparam logic [3:0] SYNC_PERIOD_FAST = 4'h4;
	localparam int FIXED_PERIOD_SLOW = 64;
	localparam int FIXED_PERIOD_FAST = 32;
	localparam int OVERSAMPLE = 16;
	localparam logic [1:0] FIXED_PRESCALE_SLOW = 2'(FIXED_PERIOD_SLOW / OVERSAMPLE - 1);
	localparam logic [1:0] FIXED_PRESCALE_FAST = 2'(FIXED_PERIOD_FAST / OVERSAMPLE - 1);
	localparam logic [3:0] PHASE_MID = 4'(OVERSAMPLE / 2 - 1);
	localparam logic [3:0] PHASE_LAST = 4'(OVERSAMPLE - 1);

	localparam logic [3:0] SYNC_BITS = 4'h8;
	localparam logic [3:0] ASYNC_RX_SAMPLES = 4'h9;
	localparam logic [3:0] FRAME_BITS_SHORT = 4'ha;
	localparam logic [3:0] FRAME_BITS_LONG = 4'hb;

	localparam int BUFFER_DEPTH = 2;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} scp_sfr_req_s;

	typedef struct packed {
		logic ninthValid;
		logic ninth;
		logic [7:0] data;
	} scp_rx_word_s;

endpackage : scp_pkg

// *** core/scp_rx_buffer.sv ***
// Two-entry buffer between the receive shifter and the receive buffer register.
`timescale 1ns/1ps
module scp_rx_buffer (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic inValid,
	input scp_pkg::scp_rx_word_s inWord,
	output logic inReady,
	output logic outValid,
	input wire logic outReady,
	output scp_pkg::scp_rx_word_s outWord
);

	typedef struct packed {
		scp_pkg::scp_rx_word_s [scp_pkg::BUFFER_DEPTH-1:0] mem;
		logic wrPtr;
		logic rdPtr;
		logic [1:0] count;
	} scp_buf_s;

	scp_buf_s q;
	scp_buf_s d;
	logic push;
	logic pop;

	assign inReady = (q.count != 2'(scp_pkg::BUFFER_DEPTH));
	assign outValid = (q.count != 2'h0);
	assign outWord = q.mem[q.rdPtr];

	always_comb begin
		d = q;
		push = inValid && inReady;
		pop = outValid && outReady;
		if (push) begin
			d.mem[q.wrPtr] = inWord;
			d.wrPtr = ~q.wrPtr;
		end
		if (pop) begin
			d.rdPtr = ~q.rdPtr;
		end
		d.count = q.count + 2'(push) - 2'(pop);
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule : scp_rx_buffer

// *** core/scp_serial_one.sv ***
// Serial port one: control register, framing, bit timing and completion flags.
`timescale 1ns/1ps
module scp_serial_one (
	input wire logic mclk,
	input wire logic reset_n,
	input scp_pkg::scp_sfr_req_s sfrReq,
	output logic [7:0] sfrRdata,
	input wire logic timerSelect,
	input wire logic timer1Overflow,
	input wire logic timer2Overflow,
	input wire logic rateDoubleSelect,
	input wire logic rxdIn,
	output logic rxdOut,
	output logic rxdOe,
	output logic txdOut,
	output logic serialIrq
);

	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_SYNC = 3'b010,
		TX_ASYNC = 3'b100
	} scp_tx_e;

	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_SYNC = 4'b0010,
		RX_START = 4'b0100,
		RX_FRAME = 4'b1000
	} scp_rx_e;

	typedef struct packed {
		logic [7:0] ctrl;
		scp_tx_e txState;
		scp_rx_e rxState;
		logic [10:0] txShift;
		logic [3:0] txBits;
		logic [3:0] txPhase;
		logic [3:0] syncCnt;
		logic [8:0] rxShift;
		logic [3:0] rxBits;
		logic [3:0] rxPhase;
		logic rxdPrev;
		logic [1:0] preCnt;
		logic ovfHalf;
		logic [7:0] rxHold;
		logic [7:0] rdata;
		logic txd;
		logic rxdDrive;
		logic rxdOutBit;
		logic irq;
	} scp_state_s;

	scp_state_s q;
	scp_state_s d;

	logic pushValid;
	logic pushReady;
	scp_pkg::scp_rx_word_s pushWord;
	logic popValid;
	logic popReady;
	scp_pkg::scp_rx_word_s popWord;

	function automatic logic nineBitMode(input logic [1:0] mode);
		return mode[1];
	endfunction : nineBitMode

	function automatic logic [3:0] syncPeriod(input logic fast);
		return fast ? scp_pkg::SYNC_PERIOD_FAST : scp_pkg::SYNC_PERIOD_SLOW;
	endfunction : syncPeriod

	scp_rx_buffer rxBuffer (
		.mclk(mclk),
		.reset_n(reset_n),
		.inValid(pushValid),
		.inWord(pushWord),
		.inReady(pushReady),
		.outValid(popValid),
		.outReady(popReady),
		.outWord(popWord)
	);

	// A word waits in the buffer while the receive flag is still up.
	assign popReady = !q.ctrl[scp_pkg::BIT_RX_COMPLETE];

	assign sfrRdata = q.rdata;
	assign txdOut = q.txd;
	assign rxdOut = q.rxdOutBit;
	assign rxdOe = q.rxdDrive;
	assign serialIrq = q.irq;

	always_comb begin
		logic [1:0] mode;
		logic multiproc;
		logic rxEnable;
		logic tick;
		logic overflow;
		logic [3:0] period;
		logic [3:0] frameBits;
		logic setTx;
		logic wrBuffer;
		logic sample;

		d = q;
		mode = {q.ctrl[scp_pkg::BIT_MODE_HIGH], q.ctrl[scp_pkg::BIT_MODE_LOW]};
		multiproc = q.ctrl[scp_pkg::BIT_MULTIPROC];
		rxEnable = q.ctrl[scp_pkg::BIT_RX_ENABLE];
		period = syncPeriod(multiproc);
		frameBits = nineBitMode(mode) ? scp_pkg::FRAME_BITS_LONG
			: scp_pkg::FRAME_BITS_SHORT;
		setTx = 1'b0;
		pushValid = 1'b0;
		pushWord = '0;
		sample = 1'b0;
		wrBuffer = sfrReq.wr && (sfrReq.addr == scp_pkg::ADDR_BUFFER);

		// Oversampling tick: sixteen per bit in every asynchronous mode.
		tick = 1'b0;
		overflow = timerSelect ? timer2Overflow : timer1Overflow;
		if (mode == scp_pkg::MODE_ASYNC11_FIXED) begin
			if (q.preCnt == (rateDoubleSelect ? scp_pkg::FIXED_PRESCALE_FAST
					: scp_pkg::FIXED_PRESCALE_SLOW)) begin
				d.preCnt = 2'h0;
				tick = 1'b1;
			end else begin
				d.preCnt = q.preCnt + 2'h1;
			end
		end else if (overflow) begin
			// Without rate doubling every second overflow makes a tick.
			d.ovfHalf = ~q.ovfHalf;
			tick = rateDoubleSelect || q.ovfHalf;
		end

		// Register writes; a hardware set below overrides a clear here.
		if (sfrReq.wr && (sfrReq.addr == scp_pkg::ADDR_CONTROL)) begin
			d.ctrl = sfrReq.wdata;
		end

		// Mode 0 shift clock divider runs only while shifting.
		if ((q.txState == TX_SYNC) || (q.rxState == RX_SYNC)) begin
			d.syncCnt = (q.syncCnt == period - 4'h1) ? 4'h0 : q.syncCnt + 4'h1;
		end else begin
			d.syncCnt = 4'h0;
		end

		unique case (q.txState)
			TX_IDLE: begin
				d.txd = 1'b1;
				d.rxdDrive = 1'b0;
				if (wrBuffer) begin
					d.txBits = 4'h0;
					d.txPhase = 4'h0;
					if (mode == scp_pkg::MODE_SYNC) begin
						if (q.rxState == RX_IDLE) begin
							d.txShift = {3'h7, sfrReq.wdata};
							d.txState = TX_SYNC;
						end
					end else begin
						d.txShift = {1'b1, nineBitMode(mode)
							? q.ctrl[scp_pkg::BIT_TX_NINTH] : 1'b1,
							sfrReq.wdata, 1'b0};
						d.txState = TX_ASYNC;
					end
				end
			end
			TX_SYNC: begin
				d.rxdDrive = 1'b1;
				d.rxdOutBit = q.txShift[0];
				d.txd = (q.syncCnt >= (period >> 1));
				if (q.syncCnt == period - 4'h1) begin
					d.txShift = {1'b1, q.txShift[10:1]};
					d.txBits = q.txBits + 4'h1;
					if (q.txBits == scp_pkg::SYNC_BITS - 4'h1) begin
						setTx = 1'b1;
						d.txState = TX_IDLE;
					end
				end
			end
			TX_ASYNC: begin
				d.txd = q.txShift[0];
				if (tick) begin
					d.txPhase = q.txPhase + 4'h1;
					if (q.txPhase == scp_pkg::PHASE_LAST) begin
						d.txShift = {1'b1, q.txShift[10:1]};
						d.txBits = q.txBits + 4'h1;
						if (q.txBits == frameBits - 4'h2) begin
							setTx = 1'b1;
						end
						if (q.txBits == frameBits - 4'h1) begin
							d.txState = TX_IDLE;
						end
					end
				end
			end
		endcase

		d.rxdPrev = rxdIn;
		unique case (q.rxState)
			RX_IDLE: begin
				d.rxBits = 4'h0;
				d.rxPhase = 4'h0;
				// A new frame is only begun while the buffer can take it.
				if (rxEnable && pushReady) begin
					if (mode == scp_pkg::MODE_SYNC) begin
						// A word still on its way to the flag must not start another reception.
						if (!q.ctrl[scp_pkg::BIT_RX_COMPLETE] && !popValid
								&& (q.txState == TX_IDLE)) begin
							d.rxState = RX_SYNC;
						end
					end else if (q.rxdPrev && !rxdIn) begin
						d.rxState = RX_START;
					end
				end
			end
			RX_SYNC: begin
				d.txd = (q.syncCnt >= (period >> 1));
				if (q.syncCnt == (period >> 1)) begin
					d.rxShift = {1'b0, rxdIn, q.rxShift[7:1]};
				end
				if (q.syncCnt == period - 4'h1) begin
					d.rxBits = q.rxBits + 4'h1;
					if (q.rxBits == scp_pkg::SYNC_BITS - 4'h1) begin
						pushValid = 1'b1;
						pushWord = '{ninthValid: 1'b0, ninth: 1'b0,
							data: q.rxShift[7:0]};
						d.rxState = RX_IDLE;
					end
				end
			end
			RX_START: begin
				if (tick) begin
					d.rxPhase = q.rxPhase + 4'h1;
					if (q.rxPhase == scp_pkg::PHASE_MID) begin
						d.rxPhase = 4'h0;
						// A start bit that has gone high again was a glitch.
						d.rxState = rxdIn ? RX_IDLE : RX_FRAME;
					end
				end
			end
			RX_FRAME: begin
				if (tick) begin
					d.rxPhase = q.rxPhase + 4'h1;
					sample = (q.rxPhase == scp_pkg::PHASE_LAST);
				end
				if (sample) begin
					d.rxShift = {rxdIn, q.rxShift[8:1]};
					d.rxBits = q.rxBits + 4'h1;
					if (q.rxBits == scp_pkg::ASYNC_RX_SAMPLES - 4'h1) begin
						d.rxState = RX_IDLE;
						// Last sample is the stop bit in mode 1, the ninth bit otherwise.
						if (!multiproc || rxdIn) begin
							pushValid = 1'b1;
							pushWord = '{ninthValid: 1'b1, ninth: rxdIn,
								data: q.rxShift[8:1]};
						end
					end
				end
			end
		endcase
		if (!rxEnable && (q.rxState != RX_IDLE)) begin
			d.rxState = RX_IDLE;
		end

		if (popValid && popReady) begin
			d.rxHold = popWord.data;
			if (popWord.ninthValid) begin
				d.ctrl[scp_pkg::BIT_RX_NINTH] = popWord.ninth;
			end
			d.ctrl[scp_pkg::BIT_RX_COMPLETE] = 1'b1;
		end
		if (setTx) begin
			d.ctrl[scp_pkg::BIT_TX_COMPLETE] = 1'b1;
		end

		if (sfrReq.rd) begin
			if (sfrReq.addr == scp_pkg::ADDR_CONTROL) begin
				d.rdata = q.ctrl;
			end else if (sfrReq.addr == scp_pkg::ADDR_BUFFER) begin
				d.rdata = q.rxHold;
			end else begin
				d.rdata = scp_pkg::UNMAPPED_READ;
			end
		end

		d.irq = d.ctrl[scp_pkg::BIT_TX_COMPLETE] || d.ctrl[scp_pkg::BIT_RX_COMPLETE];
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			q <= '{ctrl: scp_pkg::CONTROL_RESET, txState: TX_IDLE, rxState: RX_IDLE,
				txShift: '1, rxHold: scp_pkg::BUFFER_RESET, txd: 1'b1, rxdPrev: 1'b1,
				default: '0};
		end else begin
			q <= d;
		end
	end

endmodule : scp_serial_one

// *** tb/scp_serial_one_props.sv ***
// Port assertions for serial port one.
`timescale 1ns/1ps
module scp_serial_one_props (
	input wire logic mclk,
	input wire logic reset_n,
	input scp_pkg::scp_sfr_req_s sfrReq,
	input wire logic [7:0] sfrRdata,
	input wire logic rxdOe,
	input wire logic txdOut,
	input wire logic serialIrq
);
	// Hardware never touches bits 7 to 3, so a shadow of the writes predicts them.
	logic [4:0] swQ;
	logic rdC;
	logic rdX;
	assign rdC = sfrReq.rd && sfrReq.addr == scp_pkg::ADDR_CONTROL;
	assign rdX = sfrReq.rd && !rdC && sfrReq.addr != scp_pkg::ADDR_BUFFER;
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			swQ <= 5'h00;
		end else if (sfrReq.wr && sfrReq.addr == scp_pkg::ADDR_CONTROL) begin
			swQ <= sfrReq.wdata[7:3];
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	AST_CTL_READBACK: assert property ($past(rdC) |-> sfrRdata[7:3] == $past(swQ))
		else $error("control bits read back wrong");
	AST_UNMAPPED_ZERO: assert property ($past(rdX) |-> sfrRdata == scp_pkg::UNMAPPED_READ)
		else $error("unmapped read not zero");
	AST_RDATA_HOLD: assert property (!$past(sfrReq.rd) |-> $stable(sfrRdata))
		else $error("read data moved without a read");
	AST_IRQ_FLAGS: assert property ($past(rdC) |-> (|sfrRdata[1:0]) == $past(serialIrq))
		else $error("interrupt disagrees with flags");
	AST_ASYNC_NO_OE: assert property ((swQ[4:3] != 2'h0 && !rxdOe) |=> !rxdOe)
		else $error("data pin driven in async mode");
	AST_SYNC_SLOW_LOW: assert property ((swQ[4:2] == 3'h0 && $fell(txdOut))
		|-> !txdOut [*6] ##1 txdOut) else $error("slow shift clock low half wrong");
	AST_SYNC_FAST_LOW: assert property ((swQ[4:2] == 3'h1 && $fell(txdOut))
		|-> !txdOut [*2] ##1 txdOut) else $error("fast shift clock low half wrong");
	AST_SYNC_TX_FLAG: assert property ((swQ[4:3] == 2'h0 && $fell(rxdOe)) |-> ##[0:1] serialIrq)
		else $error("no flag after sync transmit");
endmodule : scp_serial_one_props
bind scp_serial_one scp_serial_one_props props_u (.mclk(mclk), .reset_n(reset_n),
	.sfrReq(sfrReq), .sfrRdata(sfrRdata), .rxdOe(rxdOe), .txdOut(txdOut), .serialIrq(serialIrq));

// *** tb/scp_line_model.sv ***
// Remote serial device on the line side of serial port one.
`timescale 1ns/1ps
module scp_line_model (
	input wire logic mclk,
	input wire logic txdOut,
	input wire logic rxdOut,
	input wire logic rxdOe,
	output logic rxdIn
);
	logic drv = 1'h1;
	// The data pin shows the port's rxdOut while rxdOe is high, and otherwise the model's drv, which rests high.
	assign rxdIn = rxdOe ? rxdOut : drv;
	task automatic sendAsync(input logic [10:0] f, input int n, input int bt);
		for (int i = 0; i < n; i++) begin
			drv = f[i];
			repeat (bt) @(negedge mclk);
		end
		drv = 1'h1;
	endtask : sendAsync
	task automatic getAsync(input int n, input int bt, output logic [10:0] f);
		f = 11'h000;
		@(negedge txdOut);
		repeat (bt / 2) @(negedge mclk);
		for (int i = 0; i < n; i++) begin
			f[i] = txdOut;
			repeat (bt) @(negedge mclk);
		end
	endtask : getAsync
	// Pin values are taken and changed on the falling clock, clear of the design's edge.
	task automatic getSync(output logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(posedge txdOut);
			@(negedge mclk);
			b[i] = rxdOut;
		end
	endtask : getSync
	task automatic putSync(input logic [7:0] b);
		drv = b[0];
		@(negedge txdOut);
		for (int i = 1; i < 8; i++) begin
			@(negedge txdOut);
			@(negedge mclk);
			drv = b[i];
		end
		@(posedge txdOut);
		@(negedge mclk);
		drv = 1'h1;
	endtask : putSync
endmodule : scp_line_model

// *** tb/serial_port_one_controller_test.sv ***
// Self-checking bench for serial port one and its line partner.
`timescale 1ns/1ps
module serial_port_one_controller_test;
	localparam logic [7:0] CA = scp_pkg::ADDR_CONTROL;
	localparam logic [7:0] BA = scp_pkg::ADDR_BUFFER;
	logic mclk = 1'h0;
	logic reset_n = 1'h0;
	scp_pkg::scp_sfr_req_s req = '0;
	logic [7:0] rdata;
	logic tSel = 1'h0;
	logic ov1 = 1'h0;
	logic ov2 = 1'h0;
	logic dbl = 1'h1;
	logic rxdIn;
	logic rxdOut;
	logic rxdOe;
	logic txdOut;
	logic irq;
	logic [31:0] rng = 32'h17;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	scp_serial_one dut_u (.mclk(mclk), .reset_n(reset_n), .sfrReq(req), .sfrRdata(rdata),
		.timerSelect(tSel), .timer1Overflow(ov1), .timer2Overflow(ov2),
		.rateDoubleSelect(dbl), .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe),
		.txdOut(txdOut), .serialIrq(irq));
	scp_line_model line_u (.mclk(mclk), .txdOut(txdOut), .rxdOut(rxdOut), .rxdOe(rxdOe),
		.rxdIn(rxdIn));
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	// An overflow every second clock gives async bits of 32 clocks, 64 without doubling, as mode 2.
	always @(negedge mclk) begin
		ov1 <= !ov1 && !tSel;
		ov2 <= !ov2 && tSel;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge mclk);
		req = '{wr, !wr, a, d};
		@(negedge mclk);
		req = '0;
		q = rdata;
	endtask : acc
	task automatic waitIrq(input int lim, output logic hit);
		for (int i = 0; i < lim && irq !== 1'h1; i++) @(negedge mclk);
		hit = irq;
	endtask : waitIrq
	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : rnd
	function automatic logic [10:0] frame(input logic [7:0] d, input logic b9, input logic m1);
		return m1 ? {2'h1, d, 1'h0} : {1'h1, b9, d, 1'h0};
	endfunction : frame
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		logic [7:0] d;
		logic [7:0] q;
		logic [7:0] ctl;
		logic [10:0] f;
		logic [1:0] m;
		logic b9;
		logic mp;
		logic hit;
		int n;
		int bt;
		repeat (5) @(negedge mclk);
		reset_n = 1'h1;
		acc(1'h0, CA, 8'h00, q);
		check("control", q, scp_pkg::CONTROL_RESET);
		acc(1'h0, 8'h5a, 8'h00, q);
		check("unmapped", q, scp_pkg::UNMAPPED_READ);
		for (int k = 0; k < 6; k++) begin
			m = 2'(1 + k % 3);
			mp = k > 2 && m != 2'h1;
			n = m == 2'h1 ? 10 : 11;
			d = 8'(rnd());
			b9 = 1'(rnd());
			tSel = 1'(rnd());
			dbl = 1'(rnd());
			bt = dbl ? 32 : 64;
			ctl = {m, mp, 1'h1, b9, 3'h0};
			acc(1'h1, CA, ctl, q);
			fork
				line_u.getAsync(n, bt, f);
				acc(1'h1, BA, d, q);
			join
			check("frame", f, frame(d, b9, m == 2'h1));
			acc(1'h0, CA, 8'h00, q);
			check("tx flag", q, ctl | 8'h02);
			acc(1'h1, CA, ctl, q);
			d = 8'(rnd());
			b9 = 1'(rnd());
			line_u.sendAsync(frame(d, b9, m == 2'h1), n, bt);
			waitIrq(64, hit);
			check("rx flag", hit, !mp || b9);
			if (hit) begin
				acc(1'h0, CA, 8'h00, q);
				check("rx ninth", q, {ctl[7:3], m == 2'h1 || b9, 2'h1});
				acc(1'h0, BA, 8'h00, q);
				check("rx data", q, d);
			end
			acc(1'h1, CA, ctl, q);
		end
		acc(1'h1, CA, 8'h80, q);
		line_u.sendAsync(frame(8'ha5, 1'h1, 1'h0), 11, bt);
		waitIrq(64, hit);
		check("rx off", hit, 1'h0);
		for (int j = 0; j < 2; j++) begin
			ctl = {2'h0, 1'(j), 5'h00};
			d = 8'(rnd());
			acc(1'h1, CA, ctl, q);
			fork
				line_u.getSync(f[7:0]);
				acc(1'h1, BA, d, q);
			join
			check("sync tx", f[7:0], d);
			waitIrq(16, hit);
			check("sync tx flag", hit, 1'h1);
			d = 8'(rnd());
			fork
				line_u.putSync(d);
				acc(1'h1, CA, ctl | 8'h14, q);
			join
			waitIrq(16, hit);
			acc(1'h0, CA, 8'h00, q);
			check("sync rx flag", q, ctl | 8'h15);
			acc(1'h0, BA, 8'h00, q);
			check("sync rx data", q, d);
			acc(1'h1, CA, 8'h00, q);
		end
		complete_run();
	end
endmodule : serial_port_one_controller_test
